// >>> hdl/pem_consts.svh
// register offsets, field positions and reset values of the port e pin block
// Function
// - direction one enables driver, zero disables it
// - reset clears all six direction bits
// - data read returns latch where direction one
// - data read returns pin where direction zero
// - data write always updates latch only
// - usb on: pin 2 is d plus, gated pull
// - kbd clock: pin 2 open drain, pull choice
// - gpio pin 2 open drain, pull choice
// - d plus pull overrides pin 2 5k pull
// - usb on: pins 3,2 ignore direction, 5k pulls
// - pin 3 irq mode: input feeding interrupt
// - pin 3 gpio: input or open drain
// - 5k pulls only while usb is off
// - spi on: pins 7..4 owned by spi
// - spi pins: direction still selects readback
// - usb off: pins 3,2 open drain outputs
// - pin 3 pull never while d minus
`ifndef PEM_CONSTS_SVH
`define PEM_CONSTS_SVH
`define PEM_ADR_LATCH 8'h08
`define PEM_ADR_DIR 8'h0c
`define PEM_ADR_OPT 8'h10
`define PEM_ADR_PINS 8'h14
`define PEM_DIR_RST 6'h00
`define PEM_LATCH_RST 6'h00
`define PEM_OPT_RST 7'h00
`define PEM_OPT_USB 0
`define PEM_OPT_KBD 1
`define PEM_OPT_P2PULL 2
`define PEM_OPT_P3PULL 3
`define PEM_OPT_DPPULL 4
`define PEM_OPT_IRQ 5
`define PEM_OPT_SPI 6
`define PEM_PORT_LO 2
`define PEM_PORT_HI 7
`endif

// >>> hdl/pem_pkg.sv
// types shared by the port e pin block
package pem_pkg;
  typedef logic [5:0] pem_port_t;
  typedef logic [6:0] pem_opt_t;
  typedef enum logic {PEM_BUS_IDLE, PEM_BUS_ACK} pem_bus_e;
endpackage

// >>> hdl/pem_mux_if.sv
// signals between the port top and the pin 3..2 function mux
`timescale 1ns/100ps
interface pem_mux_if;
  logic usb_on;
  logic kbd_on;
  logic p2_pull;
  logic p3_pull;
  logic dplus_pull;
  logic irq_on;
  logic [1:0] dir;
  logic [1:0] latch;
  logic dp_out;
  logic dp_oe;
  logic dm_out;
  logic dm_oe;
  logic kbd_low;
  logic [1:0] pad_out;
  logic [1:0] pad_oe;
  logic vref_pull;
  logic reg_pull;
  logic [1:0] pull5k;
  logic irq_sel;
  modport ctrl (output usb_on, kbd_on, p2_pull, p3_pull, dplus_pull, irq_on, dir, latch,
    dp_out, dp_oe, dm_out, dm_oe, kbd_low,
    input pad_out, pad_oe, vref_pull, reg_pull, pull5k, irq_sel);
  modport mux (input usb_on, kbd_on, p2_pull, p3_pull, dplus_pull, irq_on, dir, latch,
    dp_out, dp_oe, dm_out, dm_oe, kbd_low,
    output pad_out, pad_oe, vref_pull, reg_pull, pull5k, irq_sel);
endinterface // pem_mux_if

// >>> hdl/pem_pin23_mux.sv
// priority mux for the usb capable pins 2 and 3
`timescale 1ns/100ps
module pem_pin23_mux
  import pem_pkg::*;
(
  pem_mux_if.mux mx
);
  // index 0 is pin 2, index 1 is pin 3; open drain means output low, enable pulls down
  always_comb
  begin
    mx.pad_out = 2'b00;
    mx.pad_oe = 2'b00;
    mx.vref_pull = 1'b0;
    mx.reg_pull = 1'b0;
    mx.pull5k = 2'b00;
    mx.irq_sel = 1'b0;
    if (mx.usb_on)
    begin
      // direction and 5k pulls ignored here
      mx.pad_out[0] = mx.dp_out;
      mx.pad_oe[0] = mx.dp_oe;
      mx.vref_pull = mx.dplus_pull;
      mx.pad_out[1] = mx.dm_out;
      mx.pad_oe[1] = mx.dm_oe;
    end
    else
    begin
      if (mx.kbd_on)
      begin
        mx.pad_oe[0] = mx.kbd_low;
      end
      else
      begin
        mx.pad_oe[0] = mx.dir[0] & ~mx.latch[0];
      end
      // d plus pull wins so the two never load the pin together
      mx.reg_pull = mx.dplus_pull;
      mx.pull5k[0] = ~mx.dplus_pull & mx.p2_pull;
      mx.pull5k[1] = mx.p3_pull;
      if (mx.irq_on)
      begin
        mx.irq_sel = 1'b1;
      end
      else
      begin
        mx.pad_oe[1] = mx.dir[1] & ~mx.latch[1];
      end
    end
  end
endmodule // pem_pin23_mux

// >>> hdl/pem_gpio_top.sv
// port e pins: wishbone registers, pin muxing and registered pad controls
`timescale 1ns/100ps
`include "pem_consts.svh"
module pem_gpio_top
  import pem_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [5:0] pad_in_i,
  output logic [5:0] pad_out_o,
  output logic [5:0] pad_oe_o,
  output logic pin2_5k_pull_o,
  output logic pin3_5k_pull_o,
  output logic pin2_reg_pull_o,
  output logic dplus_vref_pull_o,
  input wire logic usb_dp_out_i,
  input wire logic usb_dp_oe_i,
  input wire logic usb_dm_out_i,
  input wire logic usb_dm_oe_i,
  output logic usb_dp_in_o,
  output logic usb_dm_in_o,
  input wire logic kbd_clk_low_i,
  input wire logic [3:0] spi_out_i,
  input wire logic [3:0] spi_oe_i,
  output logic [3:0] spi_in_o,
  output logic pin3_irq_level_o
);

  pem_bus_e bus_st_q;
  pem_bus_e bus_st_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  pem_port_t latch_q;
  pem_port_t latch_d;
  pem_port_t dir_q;
  pem_port_t dir_d;
  pem_opt_t opt_q;
  pem_opt_t opt_d;
  pem_port_t pad_out_q;
  pem_port_t pad_out_d;
  pem_port_t pad_oe_q;
  pem_port_t pad_oe_d;
  logic [3:0] pull_q;
  logic [3:0] pull_d;
  logic [1:0] usb_in_q;
  logic [1:0] usb_in_d;
  logic [3:0] spi_in_q;
  logic [3:0] spi_in_d;
  logic irq_lvl_q;
  logic irq_lvl_d;
  logic req;

  pem_mux_if mx ();

  // readback view; direction picks latch or pin even for spi pins
  function automatic pem_port_t port_view(input pem_port_t dir, input pem_port_t lat,
    input pem_port_t pin);
    port_view = (dir & lat) | (~dir & pin);
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] adr, input pem_port_t dir,
    input pem_port_t lat, input pem_port_t pin, input pem_opt_t opt);
    logic [31:0] w;
    w = 32'h0000_0000;
    // bits 1:0 read back as zero except at the option register, where they are opt bits 1:0
    if (adr == `PEM_ADR_LATCH)
      w[`PEM_PORT_HI:`PEM_PORT_LO] = port_view(dir, lat, pin);
    else if (adr == `PEM_ADR_DIR)
      w[`PEM_PORT_HI:`PEM_PORT_LO] = dir;
    else if (adr == `PEM_ADR_OPT)
      w[6:0] = opt;
    else if (adr == `PEM_ADR_PINS)
      w[`PEM_PORT_HI:`PEM_PORT_LO] = pin;
    read_word = w;
  endfunction

  assign req = wb_cyc_i & wb_stb_i;

  // bus slave: answers every address one cycle after the request, writes land on the ack edge
  always_comb
  begin
    bus_st_d = bus_st_q;
    ack_d = 1'b0;
    dat_d = dat_q;
    latch_d = latch_q;
    dir_d = dir_q;
    opt_d = opt_q;
    case (bus_st_q)
      PEM_BUS_IDLE:
      begin
        if (req)
        begin
          ack_d = 1'b1;
          dat_d = read_word(wb_adr_i, dir_q, latch_q, pad_in_i, opt_q);
          bus_st_d = PEM_BUS_ACK;
        end
      end
      PEM_BUS_ACK:
      begin
        bus_st_d = PEM_BUS_IDLE;
        if (req && wb_we_i && wb_sel_i[0])
        begin
          // latch and direction store only bits 7:2, writes to 1:0 fall away; the option register stores bits 6:0
          if (wb_adr_i == `PEM_ADR_LATCH)
            latch_d = wb_dat_i[`PEM_PORT_HI:`PEM_PORT_LO];
          else if (wb_adr_i == `PEM_ADR_DIR)
            dir_d = wb_dat_i[`PEM_PORT_HI:`PEM_PORT_LO];
          else if (wb_adr_i == `PEM_ADR_OPT)
            opt_d = wb_dat_i[6:0];
        end
      end
      default:
      begin
        bus_st_d = PEM_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_st_q <= PEM_BUS_IDLE;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      latch_q <= `PEM_LATCH_RST;
      dir_q <= `PEM_DIR_RST;
      opt_q <= `PEM_OPT_RST;
    end
    else if (ce_i)
    begin
      bus_st_q <= bus_st_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      latch_q <= latch_d;
      dir_q <= dir_d;
      opt_q <= opt_d;
    end
  end

  assign mx.usb_on = opt_q[`PEM_OPT_USB];
  assign mx.kbd_on = opt_q[`PEM_OPT_KBD];
  assign mx.p2_pull = opt_q[`PEM_OPT_P2PULL];
  assign mx.p3_pull = opt_q[`PEM_OPT_P3PULL];
  assign mx.dplus_pull = opt_q[`PEM_OPT_DPPULL];
  assign mx.irq_on = opt_q[`PEM_OPT_IRQ];
  assign mx.dir = dir_q[1:0];
  assign mx.latch = latch_q[1:0];
  assign mx.dp_out = usb_dp_out_i;
  assign mx.dp_oe = usb_dp_oe_i;
  assign mx.dm_out = usb_dm_out_i;
  assign mx.dm_oe = usb_dm_oe_i;
  assign mx.kbd_low = kbd_clk_low_i;

  pem_pin23_mux u_mux (
    .mx (mx.mux)
  );

  // pad controls are registered so every pin sees a glitch free level, at one cycle of lag
  always_comb
  begin
    pad_out_d[1:0] = mx.pad_out;
    pad_oe_d[1:0] = mx.pad_oe;
    if (opt_q[`PEM_OPT_SPI])
    begin
      pad_out_d[5:2] = spi_out_i;
      pad_oe_d[5:2] = spi_oe_i;
    end
    else
    begin
      pad_out_d[5:2] = latch_q[5:2];
      pad_oe_d[5:2] = dir_q[5:2];
    end
    pull_d = {mx.vref_pull, mx.reg_pull, mx.pull5k[1], mx.pull5k[0]};
    usb_in_d = {pad_in_i[1], pad_in_i[0]};
    spi_in_d = pad_in_i[5:2];
    // idles high when not routed, so the falling edge logic sees no event
    irq_lvl_d = mx.irq_sel ? pad_in_i[1] : 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_out_q <= 6'h00;
      pad_oe_q <= 6'h00;
      pull_q <= 4'h0;
      usb_in_q <= 2'h0;
      spi_in_q <= 4'h0;
      irq_lvl_q <= 1'b1;
    end
    else if (ce_i)
    begin
      pad_out_q <= pad_out_d;
      pad_oe_q <= pad_oe_d;
      pull_q <= pull_d;
      usb_in_q <= usb_in_d;
      spi_in_q <= spi_in_d;
      irq_lvl_q <= irq_lvl_d;
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign pad_out_o = pad_out_q;
  assign pad_oe_o = pad_oe_q;
  assign pin2_5k_pull_o = pull_q[0];
  assign pin3_5k_pull_o = pull_q[1];
  assign pin2_reg_pull_o = pull_q[2];
  assign dplus_vref_pull_o = pull_q[3];
  assign usb_dp_in_o = usb_in_q[0];
  assign usb_dm_in_o = usb_in_q[1];
  assign spi_in_o = spi_in_q;
  assign pin3_irq_level_o = irq_lvl_q;

  sequence seq_req_start;
    ce_i && req && (bus_st_q == PEM_BUS_IDLE);
  endsequence

  sequence seq_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  sequence seq_data_read;
    seq_req_start ##0 (!wb_we_i && wb_adr_i == `PEM_ADR_LATCH);
  endsequence

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
      seq_req_start ##1 ce_i |-> seq_ack_pulse;
  endproperty

  AST_ACK_ONE_CYCLE: assert property (p_ack_once)
    else $error("ack not a single cycle pulse");

  AST_RESET_DIR_CLEAR: assert property (
    @(posedge clk_i) rst_i |=> dir_q == `PEM_DIR_RST && pad_oe_o == 6'h00 && !wb_ack_o)
    else $error("direction not cleared by reset");

  AST_DIR_DRIVES_OE: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i && !opt_q[`PEM_OPT_SPI] |=> pad_oe_o[5:2] == $past(dir_q[5:2]))
    else $error("direction bit does not steer driver");

  AST_READ_VIEW: assert property (
    @(posedge clk_i) disable iff (rst_i)
      seq_data_read |=> wb_ack_o &&
        wb_dat_o[7:2] == port_view($past(dir_q), $past(latch_q), $past(pad_in_i)))
    else $error("data read mixes latch and pin wrongly");

  AST_WRITE_LATCH: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i && bus_st_q == PEM_BUS_ACK && req && wb_we_i && wb_sel_i[0] &&
        wb_adr_i == `PEM_ADR_LATCH |=> latch_q == $past(wb_dat_i[7:2]) && $stable(dir_q))
    else $error("latch write lost");

  AST_USB_PIN2: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i && opt_q[`PEM_OPT_USB] |=> pad_out_o[0] == $past(usb_dp_out_i) &&
        pad_oe_o[0] == $past(usb_dp_oe_i) && dplus_vref_pull_o == $past(opt_q[`PEM_OPT_DPPULL]))
    else $error("pin 2 not following d plus");

  AST_USB_NO_5K: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i && opt_q[`PEM_OPT_USB] |=> !pin2_5k_pull_o && !pin3_5k_pull_o && !pin2_reg_pull_o &&
        pad_oe_o[1] == $past(usb_dm_oe_i))
    else $error("usb pins still take gpio settings");

  AST_PULL_PRIORITY: assert property (
    @(posedge clk_i) disable iff (rst_i)
      !(pin2_5k_pull_o && (pin2_reg_pull_o || dplus_vref_pull_o)))
    else $error("two pulls on pin 2 at once");

  AST_KBD_CLOCK: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i && !opt_q[`PEM_OPT_USB] && opt_q[`PEM_OPT_KBD] |=>
        pad_oe_o[0] == $past(kbd_clk_low_i) && !pad_out_o[0])
    else $error("pin 2 not a keyboard clock");

  AST_OPEN_DRAIN: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i && !opt_q[`PEM_OPT_USB] |=> pad_out_o[1:0] == 2'b00)
    else $error("pins 3,2 driven high while usb off");

  AST_PIN3_IRQ: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i && !opt_q[`PEM_OPT_USB] && opt_q[`PEM_OPT_IRQ] |=>
        !pad_oe_o[1] && pin3_irq_level_o == $past(pad_in_i[1]))
    else $error("pin 3 not feeding interrupt");

  AST_SPI_OWNS: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i && opt_q[`PEM_OPT_SPI] |=> pad_oe_o[5:2] == $past(spi_oe_i) &&
        pad_out_o[5:2] == $past(spi_out_i))
    else $error("spi pins not owned by spi");

  AST_LOW_BITS_ZERO: assert property (
    @(posedge clk_i) disable iff (rst_i)
      seq_req_start ##0 (wb_adr_i == `PEM_ADR_LATCH || wb_adr_i == `PEM_ADR_DIR) |=>
        wb_dat_o[1:0] == 2'b00 && wb_dat_o[31:8] == 24'h0)
    else $error("low bits read non zero");

  AST_CE_FREEZE: assert property (
    @(posedge clk_i) disable iff (rst_i)
      !ce_i |=> $stable(dir_q) && $stable(latch_q) && $stable(pad_oe_o))
    else $error("state moved with clock enable low");

  AST_SEL_GATES_WRITE: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i && bus_st_q == PEM_BUS_ACK && req && wb_we_i && !wb_sel_i[0] |=>
        $stable(latch_q) && $stable(dir_q) && $stable(opt_q))
    else $error("write landed without byte lane 0");

  AST_PIN2_GPIO: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i && !opt_q[`PEM_OPT_USB] && !opt_q[`PEM_OPT_KBD] |=>
        pad_oe_o[0] == ($past(dir_q[0]) & ~$past(latch_q[0])))
    else $error("pin 2 gpio driver wrong");

  AST_PIN3_GPIO: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i && !opt_q[`PEM_OPT_USB] && !opt_q[`PEM_OPT_IRQ] |=>
        pad_oe_o[1] == ($past(dir_q[1]) & ~$past(latch_q[1])))
    else $error("pin 3 gpio driver wrong");

  AST_PIN3_PULL: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i && !opt_q[`PEM_OPT_USB] |=> pin3_5k_pull_o == $past(opt_q[`PEM_OPT_P3PULL]))
    else $error("pin 3 pull does not follow its enable");

  AST_IRQ_IDLE_HIGH: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i && (opt_q[`PEM_OPT_USB] || !opt_q[`PEM_OPT_IRQ]) |=> pin3_irq_level_o)
    else $error("interrupt level not idle while pin 3 is not routed");

  AST_PIN_SAMPLES: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ce_i |=> usb_dm_in_o == $past(pad_in_i[1]) && spi_in_o == $past(pad_in_i[5:2]))
    else $error("pin levels not passed on");

endmodule // pem_gpio_top

// >>> tb/pem_pad_model.sv
// behavioural model of the circuitry on the six port pins
`timescale 1ns/100ps
module pem_pad_model
(
  input wire logic clk_i,
  input wire logic [5:0] pad_out_i,
  input wire logic [5:0] pad_oe_i,
  input wire logic [5:0] ext_i,
  input wire logic [5:0] ext_en_i,
  input wire logic [5:0] pull_i,
  output logic [5:0] pad_in_o
);
  logic [5:0] churn_q = 6'h15;
  // a floating pin must not look stable, so it toggles every cycle
  always_ff @(posedge clk_i)
  begin
    churn_q <= ~churn_q;
  end
  // open drain low wins over outside drive only because the pad sinks high current
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (pad_oe_i[i])
        pad_in_o[i] = pad_out_i[i];
      else if (ext_en_i[i])
        pad_in_o[i] = ext_i[i];
      else if (pull_i[i])
        pad_in_o[i] = 1'b1;
      else
        pad_in_o[i] = churn_q[i];
    end
  end
endmodule // pem_pad_model

// >>> tb/port_e_gpio_pin_mux_bench.sv
// self-checking bench for the port e pin block
`timescale 1ns/100ps
`include "pem_consts.svh"
module port_e_gpio_pin_mux_bench;
  import pem_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic [5:0] pin;
  logic [5:0] pout;
  logic [5:0] poe;
  logic [5:0] ext = 6'h00;
  logic [5:0] ext_en = 6'h3f;
  logic [5:0] lat;
  logic [5:0] dir;
  logic p2k, p3k, p2r, dpv, dpi, dmi, irql;
  logic [3:0] spi_in;
  logic [3:0] spi_out = 4'h0;
  logic [3:0] spi_oe = 4'h0;
  logic dp_out = 1'b0;
  logic dp_oe = 1'b0;
  logic dm_out = 1'b0;
  logic dm_oe = 1'b0;
  logic kbd_low = 1'b0;
  logic ce = 1'b1;
  logic [3:0] sel = 4'hf;
  logic [3:0] exp_spi;
  int err_count = 0;
  int total_checks = 0;

  pem_gpio_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(poe), .pin2_5k_pull_o(p2k),
    .pin3_5k_pull_o(p3k), .pin2_reg_pull_o(p2r), .dplus_vref_pull_o(dpv),
    .usb_dp_out_i(dp_out), .usb_dp_oe_i(dp_oe), .usb_dm_out_i(dm_out), .usb_dm_oe_i(dm_oe),
    .usb_dp_in_o(dpi), .usb_dm_in_o(dmi), .kbd_clk_low_i(kbd_low), .spi_out_i(spi_out),
    .spi_oe_i(spi_oe), .spi_in_o(spi_in), .pin3_irq_level_o(irql));
  pem_pad_model i_pads (.clk_i(clk_i), .pad_out_i(pout), .pad_oe_i(poe), .ext_i(ext),
    .ext_en_i(ext_en), .pull_i({4'h0, p3k, p2k | p2r | dpv}), .pad_in_o(pin));

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // classic cycle: hold the request until ack is sampled, then drop for a cycle
  // a hang here is ended by the watchdog, not by a count of its own
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
    chk("ack dropped", 1'b0, ack);
  endtask

  // low two bits written as ones so that dropping them can be seen
  // one more edge so that the registered pad controls show the new value
  task automatic wr(input logic [7:0] a, input logic [6:0] v);
    wb(1'b1, a, {24'h0, v[5:0], 2'b11});
    @(posedge clk_i);
  endtask

  task automatic opt(input logic [6:0] v);
    wb(1'b1, `PEM_ADR_OPT, {25'h0, v});
    repeat (2) @(posedge clk_i);
  endtask

  function automatic logic [31:0] exp_rd(input logic [5:0] d, input logic [5:0] l,
    input logic [5:0] p);
    return {24'h0, (d & l) | (~d & p), 2'b00};
  endfunction

  initial
  begin
    void'($urandom(32'hca41));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `PEM_ADR_DIR, 32'h0);
    chk("dir after reset", 32'h0, rd);
    chk("oe after reset", 6'h00, poe);
    $display("test reset done");
    repeat (30)
    begin
      lat = 6'($urandom);
      dir = 6'($urandom);
      ext <= 6'($urandom);
      wr(`PEM_ADR_LATCH, {1'b0, lat});
      wr(`PEM_ADR_DIR, {1'b0, dir});
      chk("oe pins 7..4", dir[5:2], poe[5:2]);
      chk("oe pins 3..2", dir[1:0] & ~lat[1:0], poe[1:0]);
      chk("out pins 3..2", 2'b00, pout[1:0] & poe[1:0]);
      wb(1'b0, `PEM_ADR_LATCH, 32'h0);
      chk("port read", exp_rd(dir, lat, ext), rd);
      wb(1'b0, `PEM_ADR_DIR, 32'h0);
      chk("dir read", {24'h0, dir, 2'b00}, rd);
    end
    $display("test random gpio done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `PEM_ADR_DIR, 32'h0);
    chk("dir after second reset", 32'h0, rd);
    chk("oe after second reset", 6'h00, poe);
    $display("test second reset done");
    wr(`PEM_ADR_DIR, 7'h00);
    ext <= 6'h2a;
    wr(`PEM_ADR_LATCH, 7'h15);
    chk("oe input write", 6'h00, poe);
    wb(1'b0, `PEM_ADR_LATCH, 32'h0);
    chk("input read", exp_rd(6'h00, 6'h15, 6'h2a), rd);
    wb(1'b0, `PEM_ADR_PINS, 32'h0);
    chk("pin status read", {24'h0, 6'h2a, 2'b00}, rd);
    wr(`PEM_ADR_DIR, 7'h3f);
    wb(1'b0, `PEM_ADR_LATCH, 32'h0);
    chk("latch kept", exp_rd(6'h3f, 6'h15, 6'h2a), rd);
    sel <= 4'he;
    wr(`PEM_ADR_LATCH, 7'h2a);
    sel <= 4'hf;
    wb(1'b0, `PEM_ADR_LATCH, 32'h0);
    chk("write without lane 0", exp_rd(6'h3f, 6'h15, 6'h2a), rd);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, rd);
    $display("test latch done");
    dp_oe <= 1'b1;
    dp_out <= 1'b1;
    opt(7'h1d);
    chk("usb oe", 2'b01, poe[1:0]);
    chk("usb dp out", 1'b1, pout[0]);
    chk("usb 5k pulls", 2'b00, {p3k, p2k});
    chk("dp vref pull on", 1'b1, dpv);
    chk("dp in", 1'b1, dpi);
    chk("dm in", ext[1], dmi);
    wb(1'b0, `PEM_ADR_OPT, 32'h0);
    chk("option read", 32'h1d, rd);
    opt(7'h0d);
    chk("dp vref pull off", 1'b0, dpv);
    dp_oe <= 1'b0;
    opt(7'h14);
    chk("reg pull wins", 2'b10, {p2r, p2k});
    chk("vref pull usb off", 1'b0, dpv);
    opt(7'h04);
    chk("pin2 5k pull", 2'b01, {p2r, p2k});
    opt(7'h08);
    chk("pin3 5k pull", 1'b1, p3k);
    $display("test usb pulls done");
    kbd_low <= 1'b1;
    opt(7'h02);
    chk("kbd clock low", 2'b10, {poe[0], pout[0] & poe[0]});
    kbd_low <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("kbd clock released", 1'b0, poe[0]);
    ext_en <= 6'h3d;
    wr(`PEM_ADR_LATCH, 7'h00);
    opt(7'h28);
    chk("irq mode oe", 1'b0, poe[1]);
    chk("irq level pulled", 1'b1, irql);
    ext_en <= 6'h3f;
    ext <= 6'h00;
    repeat (3) @(posedge clk_i);
    chk("irq level low", 1'b0, irql);
    $display("test kbd and irq done");
    spi_oe <= 4'ha;
    spi_out <= 4'hc;
    ext <= 6'($urandom);
    wr(`PEM_ADR_DIR, 7'h00);
    opt(7'h40);
    chk("spi oe", 4'ha, poe[5:2]);
    chk("spi out", 4'h8, pout[5:2] & 4'ha);
    chk("spi in", (spi_oe & spi_out) | (~spi_oe & ext[5:2]), spi_in);
    wb(1'b0, `PEM_ADR_LATCH, 32'h0);
    chk("spi pin read", exp_rd(6'h00, 6'h00, pin), rd);
    wr(`PEM_ADR_DIR, 7'h3c);
    chk("spi oe dir ignored", 4'ha, poe[5:2]);
    wb(1'b0, `PEM_ADR_LATCH, 32'h0);
    chk("spi latch read", exp_rd(6'h3c, 6'h00, pin), rd);
    // clock enable low must hold every register while the pins move
    exp_spi = (spi_oe & spi_out) | (~spi_oe & ext[5:2]);
    ce <= 1'b0;
    ext <= ~ext;
    spi_oe <= 4'h5;
    repeat (4) @(posedge clk_i);
    chk("spi in frozen", exp_spi, spi_in);
    chk("spi oe frozen", 4'ha, poe[5:2]);
    ce <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("spi oe after freeze", 4'h5, poe[5:2]);
    $display("test spi done");
    end_of_test();
  end

  initial
  begin
    #2000000;
    err_count++;
    end_of_test();
  end
endmodule // port_e_gpio_pin_mux_bench
